// ==== common/ira_if.sv ====
// Open-drain two-wire link between the bus master end and the register slave.
// Each driver has an output and an active-low enable; the wire is the wired-AND.
`timescale 1ns/1ps
interface ira_if;
	logic  m_scl_out;
	logic  m_scl_oe_n;
	logic  m_sda_out;
	logic  m_sda_oe_n;
	logic  s_sda_out;
	logic  s_sda_oe_n;
	logic  scl;
	logic  sda;

	// Pull-up level unless an enabled driver pulls low
	assign scl = m_scl_oe_n | m_scl_out;
	assign sda = (m_sda_oe_n | m_sda_out) & (s_sda_oe_n | s_sda_out);

	modport master (output m_scl_out, output m_scl_oe_n, output m_sda_out, output m_sda_oe_n,
		input scl, input sda);
	modport slave (output s_sda_out, output s_sda_oe_n, input scl, input sda);
endinterface

// ==== common/ira_pkg.sv ====
// Shared constants for the two-wire register access link: device address,
// field widths, bus levels and the divider that sets the serial clock rate.
// Assumes both ends run from one 200 MHz system clock.
package ira_pkg;
	localparam int unsigned  CLK_PERIOD_NS   = 5;
	localparam int unsigned  SCL_PERIOD_NS   = 2500;
	localparam int unsigned  SCL_QUARTER_CYC = (SCL_PERIOD_NS / CLK_PERIOD_NS) / 4;
	localparam int unsigned  REG_COUNT       = 64;
	localparam int unsigned  PTR_W           = 8;
	localparam int unsigned  DATA_W          = 16;
	localparam int unsigned  BYTE_W          = 8;
	localparam logic [4:0]   DEV_ADDR_HI     = 5'h0b;
	localparam logic         DIR_WRITE       = 1'h0;
	localparam logic         DIR_READ        = 1'h1;
	localparam logic         ACK_LVL         = 1'h0;
	localparam logic [3:0]   BITS_PER_BYTE   = 4'h8;
	localparam logic [7:0]   PTR_RESET       = 8'h00;
	localparam logic [15:0]  WORD_RESET      = 16'h0000;

	typedef enum logic [2:0] {
		IRA_S_IDLE     = 3'h0,
		IRA_S_ADDR     = 3'h1,
		IRA_S_ADDR_ACK = 3'h2,
		IRA_S_RX       = 3'h3,
		IRA_S_RX_ACK   = 3'h4,
		IRA_S_TX       = 3'h5,
		IRA_S_TX_ACK   = 3'h6
	} ira_slv_t;

	typedef enum logic [3:0] {
		IRA_M_IDLE   = 4'h0,
		IRA_M_START  = 4'h1,
		IRA_M_DEVW   = 4'h2,
		IRA_M_REG    = 4'h3,
		IRA_M_WHI    = 4'h4,
		IRA_M_WLO    = 4'h5,
		IRA_M_RSTART = 4'h6,
		IRA_M_DEVR   = 4'h7,
		IRA_M_RHI    = 4'h8,
		IRA_M_RLO    = 4'h9,
		IRA_M_STOP   = 4'ha
	} ira_mst_t;
endpackage

// ==== hdl/ira_master.sv ====
// Bus master end: runs one command per request, either a multi-word write
// or a pointer write followed by a multi-word read, and makes the serial clock.
// Assumes the slave never stretches the clock; the data line is resampled.
`timescale 1ns/1ps
module ira_master
	import ira_pkg::*;
#(
	parameter int unsigned  QUARTER = ira_pkg::SCL_QUARTER_CYC
) (
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	ira_if.master                            bus,
	input  wire logic                        cmd_valid,
	output logic                             cmd_ready,
	input  wire logic                        cmd_read,
	input  wire logic [6:0]                  cmd_dev_addr,
	input  wire logic [ira_pkg::PTR_W-1:0]   cmd_reg_addr,
	input  wire logic [3:0]                  cmd_words,
	input  wire logic [ira_pkg::DATA_W-1:0]  wdata,
	output logic                             wdata_take,
	output logic                             rd_valid,
	output logic [ira_pkg::DATA_W-1:0]       rd_data,
	output logic                             done,
	output logic                             done_nack
);
	import ira_pkg::*;

	localparam logic [15:0]  QLAST = 16'(QUARTER - 1);

	logic [1:0]         sda_sync_r;
	ira_mst_t           state_r;
	logic [15:0]        div_r;
	logic [1:0]         q_r;
	logic [3:0]         bit_r;
	logic [3:0]         left_r;
	logic               read_r;
	logic [6:0]         dev_r;
	logic [7:0]         reg_r;
	logic [15:0]        wd_r;
	logic [7:0]         rx_r;
	logic [7:0]         hi_r;
	logic               nack_r;
	logic               scl_oe_n_r;
	logic               sda_oe_n_r;
	logic               tick;
	logic               byte_st;
	logic               rd_st;
	logic               last_word;
	logic [7:0]         tx_byte;
	logic               samp;

	// Data line from the wire passes two flops before use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_sync_r <= 2'h3;
		end else begin
			sda_sync_r <= {sda_sync_r[0], bus.sda};
		end
	end

	assign samp      = sda_sync_r[1];
	assign tick      = div_r == QLAST;
	assign rd_st     = state_r == IRA_M_RHI || state_r == IRA_M_RLO;
	assign byte_st   = !(state_r inside {IRA_M_IDLE, IRA_M_START, IRA_M_RSTART, IRA_M_STOP});
	assign last_word = left_r <= 4'h1;
	assign cmd_ready = state_r == IRA_M_IDLE;

	// Byte placed on the wire in each phase of the command
	always_comb begin
		unique case (state_r)
			IRA_M_DEVW: tx_byte = {dev_r, DIR_WRITE};
			IRA_M_REG:  tx_byte = reg_r;
			IRA_M_WHI:  tx_byte = wd_r[15:8];
			IRA_M_WLO:  tx_byte = wd_r[7:0];
			IRA_M_DEVR: tx_byte = {dev_r, DIR_READ};
			default:    tx_byte = 8'hff;
		endcase
	end

	// Quarter-period divider; the serial clock is derived here, not sampled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_r <= 16'h0000;
		end else if (state_r == IRA_M_IDLE || tick) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end

	// Command sequencer and line drive
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r    <= IRA_M_IDLE;
			q_r        <= 2'h0;
			bit_r      <= 4'h0;
			left_r     <= 4'h0;
			read_r     <= 1'h0;
			dev_r      <= 7'h00;
			reg_r      <= 8'h00;
			wd_r       <= 16'h0000;
			rx_r       <= 8'h00;
			hi_r       <= 8'h00;
			nack_r     <= 1'h0;
			scl_oe_n_r <= 1'h1;
			sda_oe_n_r <= 1'h1;
			wdata_take <= 1'h0;
			rd_valid   <= 1'h0;
			rd_data    <= 16'h0000;
			done       <= 1'h0;
			done_nack  <= 1'h0;
		end else begin
			wdata_take <= 1'h0;
			rd_valid   <= 1'h0;
			done       <= 1'h0;
			if (state_r == IRA_M_IDLE) begin
				q_r <= 2'h0;
				if (cmd_valid) begin
					state_r <= IRA_M_START;
					read_r  <= cmd_read;
					dev_r   <= cmd_dev_addr;
					reg_r   <= cmd_reg_addr;
					left_r  <= cmd_words;
					nack_r  <= 1'h0;
				end
			end else if (tick) begin
				q_r <= q_r + 2'h1;
				unique case (q_r)
					2'h0: begin
						scl_oe_n_r <= 1'h0;
						if (state_r == IRA_M_STOP) begin
							sda_oe_n_r <= 1'h0;
						end else if (!byte_st) begin
							sda_oe_n_r <= 1'h1;
						end else if (bit_r == BITS_PER_BYTE) begin
							sda_oe_n_r <= !rd_st || (state_r == IRA_M_RLO && last_word);
						end else begin
							sda_oe_n_r <= rd_st || tx_byte[3'(7 - bit_r)];
						end
					end
					2'h1: begin
						scl_oe_n_r <= 1'h1;
					end
					2'h2: begin
						if (state_r == IRA_M_STOP) begin
							sda_oe_n_r <= 1'h1;
						end else if (!byte_st) begin
							sda_oe_n_r <= 1'h0;
						end
					end
					2'h3: begin
						if (state_r == IRA_M_STOP) begin
							state_r   <= IRA_M_IDLE;
							done      <= 1'h1;
							done_nack <= nack_r;
						end else begin
							scl_oe_n_r <= 1'h0;
						end
						if (state_r == IRA_M_START || state_r == IRA_M_RSTART) begin
							state_r <= (state_r == IRA_M_START) ? IRA_M_DEVW : IRA_M_DEVR;
							bit_r   <= 4'h0;
						end else if (byte_st && bit_r != BITS_PER_BYTE) begin
							rx_r  <= {rx_r[6:0], samp};
							bit_r <= bit_r + 4'h1;
						end else if (byte_st) begin
							bit_r <= 4'h0;
							if (!rd_st && samp != ACK_LVL) begin
								state_r <= IRA_M_STOP;
								nack_r  <= 1'h1;
							end else begin
								unique case (state_r)
									IRA_M_DEVW: state_r <= IRA_M_REG;
									IRA_M_REG: begin
										state_r <= read_r ? IRA_M_RSTART : IRA_M_WHI;
										if (!read_r) begin
											wd_r       <= wdata;
											wdata_take <= 1'h1;
										end
									end
									IRA_M_WHI: state_r <= IRA_M_WLO;
									IRA_M_WLO: begin
										left_r <= left_r - 4'h1;
										if (last_word) begin
											state_r <= IRA_M_STOP;
										end else begin
											state_r    <= IRA_M_WHI;
											wd_r       <= wdata;
											wdata_take <= 1'h1;
										end
									end
									IRA_M_DEVR: state_r <= IRA_M_RHI;
									IRA_M_RHI: begin
										hi_r    <= rx_r;
										state_r <= IRA_M_RLO;
									end
									default: begin
										rd_valid <= 1'h1;
										rd_data  <= {hi_r, rx_r};
										left_r   <= left_r - 4'h1;
										state_r  <= last_word ? IRA_M_STOP : IRA_M_RHI;
									end
								endcase
							end
						end
					end
				endcase
			end
		end
	end

	assign bus.m_scl_out  = 1'h0;
	assign bus.m_scl_oe_n = scl_oe_n_r;
	assign bus.m_sda_out  = 1'h0;
	assign bus.m_sda_oe_n = sda_oe_n_r;
endmodule

// ==== hdl/ira_slave.sv ====
// Register access slave: decodes start/stop, address, pointer and data bytes
// from the two-wire link and serves a bank of 16-bit registers.
// Assumes the link lines are asynchronous to clk and much slower than it.
// Functional notes
// - Master writes with direction bit zero
// - First write byte loads the pointer
// - Write data: upper byte then lower byte
// - Pointer increments per write, never wraps
// - Writes past final address are discarded
// - Two bytes form one 16-bit register
// - Master sends even count of data bytes
// - Master ends write with stop/repeated start
// - Read: set pointer, restart, direction one
// - Read returns upper byte then lower
// - Pointer increments per read until nack
// - At final address, repeat last register
// - Respond to address 01011XX
// - Receiver acknowledges each byte low
// - Low address bits follow select pins
// - Stop returns interface to idle
`timescale 1ns/1ps
module ira_slave
	import ira_pkg::*;
#(
	parameter int unsigned  NUM_REGS = ira_pkg::REG_COUNT
) (
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	ira_if.slave                             bus,
	input  wire logic                        addr_select_bit0_pin,
	input  wire logic                        addr_select_bit1_pin,
	input  wire logic                        usr_we,
	input  wire logic [ira_pkg::PTR_W-1:0]   usr_addr,
	input  wire logic [ira_pkg::DATA_W-1:0]  usr_wdata,
	output logic                             wr_valid,
	output logic [ira_pkg::PTR_W-1:0]        wr_addr,
	output logic [ira_pkg::DATA_W-1:0]       wr_data,
	output logic [ira_pkg::PTR_W-1:0]        ptr
);
	import ira_pkg::*;

	localparam int unsigned       IDX_W    = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;
	localparam logic [PTR_W-1:0]  LAST_PTR = PTR_W'(NUM_REGS - 1);

	logic [2:0]         scl_sync_r;
	logic [2:0]         sda_sync_r;
	logic [1:0]         sel0_sync_r;
	logic [1:0]         sel1_sync_r;
	ira_slv_t           state_r;
	logic [3:0]         bit_cnt_r;
	logic [7:0]         sh_r;
	logic [7:0]         tx_lo_r;
	logic               rw_r;
	logic               lo_next_r;
	logic               first_r;
	logic               wr_phase_r;
	logic [7:0]         hi_r;
	logic               at_end_r;
	logic               sda_oe_n_r;
	logic [PTR_W-1:0]   ptr_r;
	logic [DATA_W-1:0]  regs_r [NUM_REGS];
	logic               scl_rise;
	logic               scl_fall;
	logic               start_det;
	logic               stop_det;
	logic [7:0]         rx_val;
	logic               addr_hit;
	logic               rx_done;
	logic               ptr_load;
	logic               wr_go;
	logic               rd_adv;
	logic [DATA_W-1:0]  rd_word;

	// Two flops before any logic; the third stage only serves edge detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync_r  <= 3'h7;
			sda_sync_r  <= 3'h7;
			sel0_sync_r <= 2'h0;
			sel1_sync_r <= 2'h0;
		end else begin
			scl_sync_r  <= {scl_sync_r[1:0], bus.scl};
			sda_sync_r  <= {sda_sync_r[1:0], bus.sda};
			sel0_sync_r <= {sel0_sync_r[0], addr_select_bit0_pin};
			sel1_sync_r <= {sel1_sync_r[0], addr_select_bit1_pin};
		end
	end

	// Line events seen from the synchronised levels
	assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
	assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
	assign start_det = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[1] & sda_sync_r[2];
	assign stop_det  = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[1] & ~sda_sync_r[2];
	assign rx_val    = {sh_r[6:0], sda_sync_r[1]};
	// Compared once the whole byte sits in the shift register, after the eighth rise
	assign addr_hit  = sh_r[7:1] == {DEV_ADDR_HI, sel1_sync_r[1], sel0_sync_r[1]};

	// Byte-level events that move the pointer and the register bank
	assign rx_done  = (state_r == IRA_S_RX) && scl_fall && (bit_cnt_r == BITS_PER_BYTE);
	assign ptr_load = rx_done && first_r;
	assign wr_go    = rx_done && !first_r && wr_phase_r && !at_end_r && (ptr_r <= LAST_PTR);
	assign rd_adv   = (state_r == IRA_S_TX_ACK) && scl_rise && (sda_sync_r[1] == ACK_LVL) && !lo_next_r;
	assign rd_word  = (ptr_r <= LAST_PTR) ? regs_r[ptr_r[IDX_W-1:0]] : WORD_RESET;

	// Bus state machine with shift register and data line drive
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r    <= IRA_S_IDLE;
			bit_cnt_r  <= 4'h0;
			sh_r       <= 8'h00;
			tx_lo_r    <= 8'h00;
			rw_r       <= DIR_WRITE;
			lo_next_r  <= 1'h0;
			first_r    <= 1'h0;
			sda_oe_n_r <= 1'h1;
		end else if (stop_det) begin
			state_r    <= IRA_S_IDLE;
			sda_oe_n_r <= 1'h1;
		end else if (start_det) begin
			state_r    <= IRA_S_ADDR; // Repeated start restarts decode
			bit_cnt_r  <= 4'h0;
			sda_oe_n_r <= 1'h1;
		end else begin
			unique case (state_r)
				IRA_S_IDLE: begin
					sda_oe_n_r <= 1'h1;
				end
				IRA_S_ADDR, IRA_S_RX: begin
					if (scl_rise && bit_cnt_r != BITS_PER_BYTE) begin
						sh_r      <= rx_val;
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
						if (state_r == IRA_S_RX) begin
							state_r    <= IRA_S_RX_ACK;
							sda_oe_n_r <= 1'h0;
							first_r    <= 1'h0;
						end else if (addr_hit) begin
							state_r    <= IRA_S_ADDR_ACK;
							rw_r       <= sh_r[0];
							sda_oe_n_r <= 1'h0;
						end else begin
							state_r <= IRA_S_IDLE;
						end
					end
				end
				IRA_S_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (rw_r == DIR_READ) begin
							state_r    <= IRA_S_TX;
							sh_r       <= rd_word[15:8];
							tx_lo_r    <= rd_word[7:0];
							lo_next_r  <= 1'h1;
							sda_oe_n_r <= rd_word[15];
						end else begin
							state_r    <= IRA_S_RX;
							first_r    <= 1'h1;
							sda_oe_n_r <= 1'h1;
						end
					end
				end
				IRA_S_RX_ACK: begin
					if (scl_fall) begin
						state_r    <= IRA_S_RX;
						bit_cnt_r  <= 4'h0;
						sda_oe_n_r <= 1'h1;
					end
				end
				IRA_S_TX: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_r == BITS_PER_BYTE) begin
							state_r    <= IRA_S_TX_ACK;
							sda_oe_n_r <= 1'h1; // Let the master answer
						end else begin
							sh_r       <= {sh_r[6:0], 1'h0};
							sda_oe_n_r <= sh_r[6];
						end
					end
				end
				IRA_S_TX_ACK: begin
					if (scl_rise && sda_sync_r[1] != ACK_LVL) begin
						state_r <= IRA_S_IDLE;
					end else if (scl_fall) begin
						state_r   <= IRA_S_TX;
						bit_cnt_r <= 4'h0;
						lo_next_r <= !lo_next_r;
						if (lo_next_r) begin
							sh_r       <= tx_lo_r;
							sda_oe_n_r <= tx_lo_r[7];
						end else begin
							sh_r       <= rd_word[15:8];
							tx_lo_r    <= rd_word[7:0];
							sda_oe_n_r <= rd_word[15];
						end
					end
				end
				default: begin
					state_r <= IRA_S_IDLE;
				end
			endcase
		end
	end

	// Pointer, byte pairing and end-of-map flag; nothing here resets on stop
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_r      <= PTR_RESET;
			at_end_r   <= 1'h0;
			wr_phase_r <= 1'h0;
			hi_r       <= 8'h00;
		end else begin
			if (state_r == IRA_S_ADDR_ACK) begin
				wr_phase_r <= 1'h0;
			end else if (rx_done && !first_r) begin
				wr_phase_r <= !wr_phase_r;
				if (!wr_phase_r) begin
					hi_r <= sh_r;
				end
			end
			if (ptr_load) begin
				ptr_r    <= sh_r;
				at_end_r <= 1'h0;
			end else if (wr_go || rd_adv) begin
				if (ptr_r >= LAST_PTR) begin
					at_end_r <= wr_go;
				end else begin
					ptr_r <= ptr_r + 8'h01;
				end
			end
		end
	end

	// Register bank; a link write wins over a same-cycle local update
	always_ff @(posedge clk) begin
		if (wr_go) begin
			regs_r[ptr_r[IDX_W-1:0]] <= {hi_r, sh_r};
		end else if (usr_we && usr_addr <= LAST_PTR) begin
			regs_r[usr_addr[IDX_W-1:0]] <= usr_wdata;
		end
	end

	// Write notification toward local logic
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_valid <= 1'h0;
			wr_addr  <= PTR_RESET;
			wr_data  <= WORD_RESET;
		end else begin
			wr_valid <= wr_go;
			if (wr_go) begin
				wr_addr <= ptr_r;
				wr_data <= {hi_r, sh_r};
			end
		end
	end

	assign ptr            = ptr_r;
	assign bus.s_sda_out  = 1'h0;
	assign bus.s_sda_oe_n = sda_oe_n_r;
endmodule

// ==== verif/ira_assertions.sv ====
// Wire-level checks on the two-wire register link, watching the shared interface.
// Assumes one clk domain and an SCL high phase of at least 8 clocks (QUARTER >= 4).
`timescale 1ns/1ps
module ira_assertions
	import ira_pkg::*;
(
	input wire logic  clk,
	input wire logic  reset_n,
	input wire logic  s_sda_oe_n,
	input wire logic  scl,
	input wire logic  sda,
	input wire logic  addr_select_bit0_pin,
	input wire logic  addr_select_bit1_pin
);
	import ira_pkg::*;
	logic        scl_q, sda_q, first_r, match_r, rw_r;
	logic [3:0]  bit_cnt_r;
	logic [7:0]  shreg_r;
	logic        scl_rise, start_c, stop_c, addr_hit, ack_slot;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Edge and condition detection on the resolved lines
	assign scl_rise = scl & ~scl_q;
	assign start_c  = scl & scl_q & sda_q & ~sda;
	assign stop_c   = scl & scl_q & ~sda_q & sda;
	assign addr_hit = shreg_r[7:1] == {DEV_ADDR_HI, addr_select_bit1_pin, addr_select_bit0_pin};
	assign ack_slot = scl_rise & (bit_cnt_r == 4'h8);

	// Line history, released level in reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// Bit position inside the byte; a start realigns it, since any byte may be cut short
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_r <= 4'h0;
			first_r   <= 1'h0;
			shreg_r   <= 8'h00;
			rw_r      <= 1'h0;
		end else if (start_c) begin
			bit_cnt_r <= 4'h0;
			first_r   <= 1'h1;
		end else if (scl_rise) begin
			shreg_r   <= {shreg_r[6:0], sda};
			bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
			if (bit_cnt_r == 4'h8)
				first_r <= 1'h0;
			if (first_r && bit_cnt_r == 4'h7)
				rw_r <= sda;
		end
	end

	// Frame addressed to this slave
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			match_r <= 1'h0;
		else if (start_c | stop_c)
			match_r <= 1'h0;
		else if (ack_slot & first_r & addr_hit)
			match_r <= 1'h1;
	end

	chk_addr_ack: assert property (ack_slot && first_r && addr_hit |-> ##2 (!sda)[*4])
		else $error("own address not acknowledged");
	chk_addr_nack: assert property (ack_slot && first_r && !addr_hit |-> ##2 sda[*4])
		else $error("foreign address acknowledged");
	chk_write_ack: assert property (ack_slot && !first_r && match_r && !rw_r |-> ##2 (!sda)[*4])
		else $error("write byte not acknowledged");
	chk_read_release: assert property (ack_slot && !first_r && match_r && rw_r |-> ##2 s_sda_oe_n[*4])
		else $error("slave holds data line in master ack slot");
	chk_stop_idle: assert property (stop_c |-> s_sda_oe_n[*8])
		else $error("slave drives after stop");
	chk_addr_listen: assert property (first_r && bit_cnt_r < 4'h8 |-> s_sda_oe_n)
		else $error("slave drives during address byte");
	chk_sda_in_low: assert property ($changed(s_sda_oe_n) |-> !scl)
		else $error("slave data changed while clock high");
	chk_bit_steady: assert property (scl_rise && rw_r && !first_r && match_r && bit_cnt_r < 4'h8
		|-> ##1 $stable(s_sda_oe_n)[*6])
		else $error("read bit unstable in clock high");
endmodule

// ==== verif/test_i2c_register_access_slave.sv ====
// Self-checking bench: master end and register slave face each other on one link.
// Assumes QUARTER is cut to 4 so a byte takes 144 clocks; expectations are fixed words.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
	$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module test_i2c_register_access_slave;
	import ira_pkg::*;
	logic         clk, reset_n, pin0, pin1, usr_we, cmd_valid, cmd_ready, cmd_read;
	logic         wdata_take, rd_valid, done, done_nack, wr_valid;
	logic [7:0]   usr_addr, cmd_reg_addr, wr_addr, ptr;
	logic [15:0]  usr_wdata, wdata, rd_data, wr_data;
	logic [6:0]   cmd_dev_addr, dev;
	logic [3:0]   cmd_words;
	logic [23:0]  lq[$];
	logic [15:0]  rq[$];
	logic [15:0]  wq[$];
	int           err_count, num_checks;

	ira_if bus ();
	ira_master #(.QUARTER(4)) ira_master_inst (.clk(clk), .reset_n(reset_n), .bus(bus),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr),
		.cmd_reg_addr(cmd_reg_addr), .cmd_words(cmd_words), .wdata(wdata), .wdata_take(wdata_take),
		.rd_valid(rd_valid), .rd_data(rd_data), .done(done), .done_nack(done_nack));
	ira_slave #(.NUM_REGS(REG_COUNT)) ira_slave_inst (.clk(clk), .reset_n(reset_n), .bus(bus),
		.addr_select_bit0_pin(pin0), .addr_select_bit1_pin(pin1), .usr_we(usr_we), .usr_addr(usr_addr),
		.usr_wdata(usr_wdata), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .ptr(ptr));
	ira_assertions ira_assertions_inst (.clk(clk), .reset_n(reset_n), .s_sda_oe_n(bus.s_sda_oe_n),
		.scl(bus.scl), .sda(bus.sda), .addr_select_bit0_pin(pin0), .addr_select_bit1_pin(pin1));

	// 200 MHz system clock
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	// Collect landed writes and read words; feed the next write word after each take
	always @(posedge clk) begin
		if (wr_valid === 1'h1)
			lq.push_back({wr_addr, wr_data});
		if (rd_valid === 1'h1)
			rq.push_back(rd_data);
		if (wdata_take === 1'h1 && wq.size() > 0)
			wdata <= wq.pop_front();
	end

	task test_done();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One master command; master is idle on entry, so the first edge takes it
	task xfer(input logic rd, input logic [6:0] da, input logic [7:0] ra, input logic [3:0] n);
		int i;
		`CHK("cmd ready", 1'h1, cmd_ready)
		cmd_valid <= 1'h1;
		cmd_read <= rd;
		cmd_dev_addr <= da;
		cmd_reg_addr <= ra;
		cmd_words <= n;
		@(posedge clk);
		cmd_valid <= 1'h0;
		for (i = 0; i < 8000; i++) begin
			@(posedge clk);
			if (done === 1'h1)
				break;
		end
		if (i == 8000) begin
			err_count++;
			$display("MISMATCH done expected 1 seen 0");
			test_done();
		end
		repeat (8) @(posedge clk);
	endtask

	task wr(input logic [6:0] da, input logic [7:0] ra, input logic [15:0] a, b, c, input logic [3:0] n);
		wdata <= a;
		wq = {b, c};
		xfer(1'h0, da, ra, n);
	endtask

	task rd_chk(input logic [6:0] da, input logic [7:0] ra, input logic [15:0] a, b, c, input logic [3:0] n);
		logic [15:0] e[3];
		int i;
		e = '{a, b, c};
		rq = {};
		xfer(1'h1, da, ra, n);
		`CHK("read count", 32'(n), rq.size())
		for (i = 0; i < n; i++)
			`CHK("read word", e[i], rq[i])
	endtask

	// Next landed link write must be this address and word
	task lw(input logic [7:0] a, input logic [15:0] d);
		logic [23:0] g;
		g = (lq.size() > 0) ? lq.pop_front() : 24'h000000;
		`CHK("link write", {a, d}, g)
	endtask

	initial begin
		int i;
		{reset_n, pin0, pin1, usr_we, cmd_valid, cmd_read} = 6'h00;
		{usr_addr, cmd_reg_addr, cmd_dev_addr, cmd_words} = 27'h0000000;
		{usr_wdata, wdata} = 32'h00000000;
		err_count = 0;
		num_checks = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'h1;
		pin1 <= 1'h1;
		dev = {DEV_ADDR_HI, 2'b10};
		repeat (8) @(posedge clk);
		// Three words in one transfer, pointer steps per word
		wr(dev, 8'h05, 16'ha1b2, 16'hc3d4, 16'he5f6, 4'h3);
		lw(8'h05, 16'ha1b2);
		lw(8'h06, 16'hc3d4);
		lw(8'h07, 16'he5f6);
		`CHK("pointer", 8'h08, ptr)
		`CHK("nack flag", 1'h0, done_nack)
		$display("test write_run done");
		// Read back after restart, pointer set again by the command's pointer byte
		rd_chk(dev, 8'h05, 16'ha1b2, 16'hc3d4, 16'he5f6, 4'h3);
		`CHK("pointer", 8'h07, ptr)
		`CHK("stray writes", 32'd0, lq.size())
		$display("test read_run done");
		// Run over the final register: no wrap, later words dropped, reads repeat
		wr(dev, 8'd62, 16'h1111, 16'h2222, 16'h3333, 4'h3);
		lw(8'd62, 16'h1111);
		lw(8'd63, 16'h2222);
		`CHK("dropped writes", 32'd0, lq.size())
		`CHK("pointer", 8'd63, ptr)
		rd_chk(dev, 8'd62, 16'h1111, 16'h2222, 16'h2222, 4'h3);
		$display("test map_end done");
		// Select pins move the address; old and foreign addresses get no answer
		pin1 <= 1'h0;
		pin0 <= 1'h1;
		repeat (8) @(posedge clk);
		for (i = 0; i < 2; i++) begin
			wr((i == 0) ? dev : {5'h0a, 2'b01}, 8'h20, 16'h0f0f, 16'h0000, 16'h0000, 4'h1);
			`CHK("nack flag", 1'h1, done_nack)
			`CHK("foreign writes", 32'd0, lq.size())
		end
		dev = {DEV_ADDR_HI, 2'b01};
		wr(dev, 8'h20, 16'h4d4d, 16'h0000, 16'h0000, 4'h1);
		`CHK("nack flag", 1'h0, done_nack)
		lw(8'h20, 16'h4d4d);
		$display("test address_select done");
		// Local load then a single-word read of it
		usr_we <= 1'h1;
		usr_addr <= 8'h30;
		usr_wdata <= 16'h5a5a;
		@(posedge clk);
		usr_we <= 1'h0;
		rd_chk(dev, 8'h30, 16'h5a5a, 16'h0000, 16'h0000, 4'h1);
		`CHK("pointer", 8'h30, ptr)
		$display("test local_load done");
		test_done();
	end
endmodule
